// ---- include/dsr_cfg.svh ----
// Named constants for the device-select reset and port-state block.
`ifndef DSR_CFG_SVH
`define DSR_CFG_SVH

// =====================================================================
// Port direction encodings
`define DSR_DIR_INPUT   1'h0
`define DSR_DIR_OUTPUT  1'h1

// =====================================================================
// Port function encodings
`define DSR_MODE_PORT   1'h0
`define DSR_MODE_ALT    1'h1

// =====================================================================
// Reset values
`define DSR_BIT_CLR     1'h0
`define DSR_BIT_SET     1'h1
`define DSR_OE_N_OFF    1'h1

// =====================================================================
// Synchroniser to output latencies in clock cycles
`define DSR_EDGE_LAT    2
`define DSR_IRQ_LAT     3

`endif

// ---- include/dsr_pkg.sv ----
// Types shared by the device-select reset and port-state block.
package dsr_pkg;

  // ===================================================================
  // Software view of the general-purpose port bit.
  typedef struct packed {
    logic alt;   // Alternate function when set, plain port when clear.
    logic dir;   // Output when set, input when clear.
    logic out;   // Level driven while the bit is an output.
  } dsr_port_ctl_t;

  // ===================================================================
  // States of the select-pin reset sequencer.
  typedef enum logic [0:0] {
    DSR_IDLE,
    DSR_ARMED
  } dsr_state_t;

endpackage

// ---- design/dsr_top.sv ----
// Device-select pin control, select-pin reset and port bit state logic.
`timescale 1ns/1ps
`include "dsr_cfg.svh"

module dsr_top (
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   sel_pin_i,
  input  wire logic                   ext_reset_pin_i,
  input  wire logic                   watchdog_stack_fault_reset_i,
  input  wire logic                   timer_set_pulse_i,
  input  wire logic                   clk_stop_exec_i,
  input  wire logic                   clk_resume_i,
  input  wire logic                   pll_sw_enable_i,
  input  wire logic                   port_ctl_wr_i,
  input  wire dsr_pkg::dsr_port_ctl_t port_ctl_wdata_i,
  input  wire logic                   port_bit_zero_pin_i,
  output logic                        pll_enable_o,
  output logic                        sel_reset_o,
  output logic                        sel_irq_o,
  output logic                        clk_stop_o,
  output logic                        port_bit_zero_o,
  output logic                        port_bit_zero_oe_n_o,
  output logic                        port_bit_zero_rd_o,
  output logic                        port_alt_mode_o,
  output logic                        port_dir_o
);
  import dsr_pkg::*;

  // ===================================================================
  // Declarations
  logic          sel_meta_reg;
  logic          sel_sync_reg;
  logic          sel_prev_reg;
  logic          tmr_prev_reg;
  dsr_state_t    state_reg;
  dsr_state_t    state_next;
  dsr_port_ctl_t ctl_reg;
  dsr_port_ctl_t ctl_next;
  logic          stop_reg;
  logic          pll_reg;
  logic          sel_rst_reg;
  logic          irq_reg;
  logic          drv_reg;
  logic          oe_n_reg;
  logic          rd_reg;

  wire logic sel_rise;
  wire logic sel_fall;
  wire logic tmr_rise;
  wire logic hard_rst;
  wire logic fire;
  wire logic ctl_write;
  wire logic stop_next;

  // Rising edge decode of a sampled level against its previous sample.
  function automatic logic edge_up(input logic cur, input logic prev);
    edge_up = cur & ~prev;
  endfunction

  // ===================================================================
  // Select pin synchroniser
  // Only the second stage is looked at, so a slow clean edge on the
  // pin yields exactly one rise or one fall per settled transition.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sel_meta_reg <= `DSR_BIT_CLR;
      sel_sync_reg <= `DSR_BIT_CLR;
      sel_prev_reg <= `DSR_BIT_CLR;
      tmr_prev_reg <= `DSR_BIT_CLR;
    end else begin
      sel_meta_reg <= sel_pin_i;
      sel_sync_reg <= sel_meta_reg;
      sel_prev_reg <= sel_sync_reg;
      tmr_prev_reg <= timer_set_pulse_i;
    end
  end

  // Edge and event decode.
  assign sel_rise  = edge_up(sel_sync_reg, sel_prev_reg);
  assign sel_fall  = edge_up(sel_prev_reg, sel_sync_reg);
  assign tmr_rise  = edge_up(timer_set_pulse_i, tmr_prev_reg);
  assign hard_rst  = ext_reset_pin_i | watchdog_stack_fault_reset_i;
  assign fire      = (state_reg == DSR_ARMED) & tmr_rise & sel_sync_reg;

  // ===================================================================
  // Select-pin reset sequencer
  // A rise arms the sequencer; the reset fires on the next rising edge
  // of the timer setting pulse. A fall before that edge disarms it.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DSR_IDLE: begin
        if (sel_rise) begin
          state_next = DSR_ARMED;
        end
      end
      DSR_ARMED: begin
        if (fire || sel_fall) begin
          state_next = DSR_IDLE;
        end
      end
      default: begin
        state_next = DSR_IDLE;
      end
    endcase
  end

  // Sequencer state and one-cycle reset and interrupt pulses.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg   <= DSR_IDLE;
      sel_rst_reg <= `DSR_BIT_CLR;
      irq_reg     <= `DSR_BIT_CLR;
    end else begin
      state_reg   <= hard_rst ? DSR_IDLE : state_next;
      sel_rst_reg <= fire & ~hard_rst;
      irq_reg     <= sel_fall;
    end
  end

  // ===================================================================
  // PLL gate
  // A low pin level overrides software; the synchronised level is used
  // so the gate and the edge events agree on when the pin moved.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pll_reg <= `DSR_BIT_CLR;
    end else begin
      pll_reg <= sel_sync_reg & pll_sw_enable_i;
    end
  end

  // ===================================================================
  // Clock stop flag
  // A stop request in the same cycle as a resume wins over the resume.
  assign stop_next = clk_stop_exec_i | (stop_reg & ~clk_resume_i);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stop_reg <= `DSR_BIT_CLR;
    end else begin
      stop_reg <= stop_next & ~hard_rst;
    end
  end

  // ===================================================================
  // Port bit configuration
  // Writes are ignored while the clock is stopped, so the bit keeps
  // its state. The select-pin reset does not touch it at all.
  assign ctl_write = port_ctl_wr_i & ~stop_reg;

  always_comb begin
    ctl_next = ctl_reg;
    if (hard_rst) begin
      ctl_next.dir = `DSR_DIR_INPUT;
      ctl_next.alt = `DSR_MODE_PORT;
    end else if (ctl_write) begin
      ctl_next = port_ctl_wdata_i;
    end
  end

  // Configuration register; power-on puts the bit in port input mode.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctl_reg.dir <= `DSR_DIR_INPUT;
      ctl_reg.alt <= `DSR_MODE_PORT;
      ctl_reg.out <= `DSR_BIT_CLR;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // ===================================================================
  // Pin drive and gated input buffer
  // The read path is forced low while stopped so a floating pin makes
  // no switching in the logic behind it.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      drv_reg  <= `DSR_BIT_CLR;
      oe_n_reg <= `DSR_OE_N_OFF;
      rd_reg   <= `DSR_BIT_CLR;
    end else begin
      drv_reg  <= ctl_next.out;
      oe_n_reg <= ~(ctl_next.dir == `DSR_DIR_OUTPUT);
      rd_reg   <= port_bit_zero_pin_i & ~stop_next;
    end
  end

  // Outputs come straight from flip-flops.
  assign pll_enable_o         = pll_reg;
  assign sel_reset_o          = sel_rst_reg;
  assign sel_irq_o            = irq_reg;
  assign clk_stop_o           = stop_reg;
  assign port_bit_zero_o      = drv_reg;
  assign port_bit_zero_oe_n_o = oe_n_reg;
  assign port_bit_zero_rd_o   = rd_reg;
  assign port_alt_mode_o      = ctl_reg.alt;
  assign port_dir_o           = ctl_reg.dir;

  // ===================================================================
  // Assertions
  default clocking dsr_cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // Pin settles high then later low across the synchroniser.
  sequence s_sel_fell;
    sel_sync_reg ##1 !sel_sync_reg;
  endsequence

  sequence s_armed_edge;
    (state_reg == DSR_ARMED) && sel_sync_reg && tmr_rise && !hard_rst;
  endsequence

  a_irq_on_fall: assert property (
    s_sel_fell |=> sel_irq_o)
    else $error("Interrupt missing after select fall.");

  a_irq_single: assert property (
    sel_irq_o |=> !sel_irq_o)
    else $error("Interrupt pulse longer than one cycle.");

  a_pll_low_sel: assert property (
    !sel_sync_reg |=> !pll_enable_o)
    else $error("PLL enabled while select low.");

  a_pll_high_sel: assert property (
    (sel_sync_reg && pll_sw_enable_i) |=> pll_enable_o)
    else $error("PLL not enabled with select high.");

  a_reset_at_edge: assert property (
    s_armed_edge |=> sel_reset_o)
    else $error("Select reset missing at timer edge.");

  a_reset_cause: assert property (
    sel_reset_o |-> $past(tmr_rise) && ($past(state_reg) == DSR_ARMED))
    else $error("Select reset without armed timer edge.");

  a_arm_on_rise: assert property (
    (sel_rise && state_reg == DSR_IDLE && !hard_rst) |=> state_reg == DSR_ARMED)
    else $error("Sequencer not armed by select rise.");

  a_hard_input: assert property (
    hard_rst |=> (!port_dir_o && !port_alt_mode_o && port_bit_zero_oe_n_o))
    else $error("Hard reset left the bit driving.");

  a_sel_retain: assert property (
    (sel_reset_o && !hard_rst && !port_ctl_wr_i) |=> $stable(port_dir_o))
    else $error("Select reset changed port direction.");

  a_stop_retain: assert property (
    (clk_stop_o && !hard_rst) |=> $stable(ctl_reg))
    else $error("Port state changed while stopped.");

  a_stop_gates: assert property (
    clk_stop_o |-> !port_bit_zero_rd_o)
    else $error("Input buffer not gated while stopped.");

  a_dir_write: assert property (
    (port_ctl_wr_i && !clk_stop_o && !hard_rst && port_ctl_wdata_i.dir)
      |=> (port_dir_o && !port_bit_zero_oe_n_o))
    else $error("Direction write not applied.");

endmodule // dsr_top

// ---- tb/dsr_sel_ctrl.sv ----
// Behavioural model of the system controller that drives the select pin.
`timescale 1ns/1ps

// =====================================================================
module dsr_sel_ctrl (
  input  wire logic clk_i,
  output logic      sel_pin_o
);
  // The pin starts low, so the device begins deselected.
  initial sel_pin_o = 1'b0;

  // Moves the pin just after a falling edge and holds it for hold cycles.
  task automatic drive(input logic lvl, input int hold);
    @(negedge clk_i);
    sel_pin_o = lvl;
    repeat (hold) @(negedge clk_i);
  endtask
endmodule // dsr_sel_ctrl

// ---- tb/tb_dsr_top.sv ----
// Self-checking testbench for the select-pin reset and port-state block.
`timescale 1ns/1ps

module tb_dsr_top;
  import dsr_pkg::*;
  logic          clk_i = 1'b0;
  logic          sys_rst_i = 1'b1;
  logic          sel, ext_rst, wd_rst, tmr, stop, resume, pll_sw, wr, pin;
  dsr_port_ctl_t wdata;
  logic          pll_en, sel_rst, irq, stop_o, pout, oe_n, rd, alt_o, dir_o;
  int            mismatches = 0;
  int            samples_checked = 0;
  int            cycles = 0;
  int            irq_cnt = 0;
  int            rst_cnt = 0;
  int            base;
  logic [6:0]    rows [5] = '{7'h35, 7'h24, 7'h13, 7'h4A, 7'h35};

  // Clock at 100 MHz.
  always #5 clk_i = ~clk_i;

  dsr_sel_ctrl ctl_u (.clk_i(clk_i), .sel_pin_o(sel));

  dsr_top dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sel_pin_i(sel), .ext_reset_pin_i(ext_rst),
    .watchdog_stack_fault_reset_i(wd_rst), .timer_set_pulse_i(tmr),
    .clk_stop_exec_i(stop), .clk_resume_i(resume), .pll_sw_enable_i(pll_sw),
    .port_ctl_wr_i(wr), .port_ctl_wdata_i(wdata), .port_bit_zero_pin_i(pin),
    .pll_enable_o(pll_en), .sel_reset_o(sel_rst), .sel_irq_o(irq), .clk_stop_o(stop_o),
    .port_bit_zero_o(pout), .port_bit_zero_oe_n_o(oe_n), .port_bit_zero_rd_o(rd),
    .port_alt_mode_o(alt_o), .port_dir_o(dir_o));

  // Counts event pulses and cuts a hang short.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (sel_rst === 1'b1) rst_cnt <= rst_cnt + 1;
    if (cycles == 3000) begin
      mismatches++;
      print_verdict();
    end
  end

  // Compares one value and reports a difference.
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Writes the port configuration with a one-cycle strobe.
  task automatic put(input logic [2:0] d);
    @(negedge clk_i);
    wr = 1'b1;
    wdata = d;
    @(negedge clk_i);
    wr = 1'b0;
  endtask

  // Raises one input for a single cycle.
  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask

  initial begin
    {sel, ext_rst, wd_rst, tmr, stop, resume, pll_sw, wr, pin} = '0;
    wdata = '0;
    repeat (5) @(negedge clk_i);
    check("reset outs", {oe_n, pll_en, sel_rst, irq, stop_o, pout, rd, alt_o, dir_o}, 9'h100);
    sys_rst_i = 1'b0;
    // Table: written {alt,dir,out} beside expected {alt,dir,oe_n,out}.
    foreach (rows[i]) begin
      put(rows[i][6:4]);
      check("port cfg", {5'h0, alt_o, dir_o, oe_n, pout}, {5'h0, rows[i][3:0]});
    end
    $display("Test port table done");
    for (int k = 0; k < 2; k++) begin
      put(3'h7);
      if (k == 0) pulse(ext_rst); else pulse(wd_rst);
      check("hard reset", {5'h0, alt_o, dir_o, oe_n, pout}, 9'h003);
    end
    $display("Test hard resets done");
    put(3'h3);
    pll_sw = 1'b1;
    ctl_u.drive(1'b1, 6);
    check("pll on", pll_en, 9'h1);
    base = rst_cnt;
    tmr = 1'b1;
    @(negedge clk_i);
    check("sel reset", sel_rst, 9'h1);
    tmr = 1'b0;
    @(negedge clk_i);
    check("sel reset end", sel_rst, 9'h0);
    pulse(tmr);
    check("one reset", 9'(rst_cnt - base), 9'h1);
    check("port kept", {dir_o, oe_n}, 9'h2);
    pll_sw = 1'b0;
    repeat (2) @(negedge clk_i);
    check("pll sw off", pll_en, 9'h0);
    pll_sw = 1'b1;
    $display("Test select rise done");
    base = irq_cnt;
    ctl_u.drive(1'b0, 3);
    check("irq", irq, 9'h1);
    @(negedge clk_i);
    check("irq end", irq, 9'h0);
    repeat (4) @(negedge clk_i);
    check("one irq", 9'(irq_cnt - base), 9'h1);
    check("pll forced off", pll_en, 9'h0);
    $display("Test select fall done");
    base = rst_cnt;
    ctl_u.drive(1'b1, 4);
    ctl_u.drive(1'b0, 6);
    // Timer edge lands on the very cycle the new rise is first seen.
    ctl_u.drive(1'b1, 2);
    tmr = 1'b1;
    @(negedge clk_i);
    tmr = 1'b0;
    repeat (2) @(negedge clk_i);
    check("cancelled reset", 9'(rst_cnt - base), 9'h0);
    pulse(tmr);
    @(negedge clk_i);
    check("rearmed reset", 9'(rst_cnt - base), 9'h1);
    $display("Test fall while armed done");
    pin = 1'b1;
    repeat (2) @(negedge clk_i);
    check("read open", rd, 9'h1);
    pulse(stop);
    check("stopped", {stop_o, rd}, 9'h2);
    put(3'h0);
    check("write ignored", {dir_o, oe_n}, 9'h2);
    pulse(resume);
    check("resumed", {stop_o, rd}, 9'h1);
    @(negedge clk_i);
    {stop, resume} = 2'h3;
    @(negedge clk_i);
    {stop, resume} = 2'h0;
    check("stop wins", stop_o, 9'h1);
    $display("Test clock stop done");
    // Power-on reset in mid-run, then the first edge after release.
    sys_rst_i = 1'b1;
    @(negedge clk_i);
    check("mid reset", {oe_n, pll_en, sel_rst, irq, stop_o, pout, rd, alt_o, dir_o}, 9'h100);
    sys_rst_i = 1'b0;
    @(negedge clk_i);
    check("first edge", {oe_n, pll_en, sel_rst, irq, stop_o, pout, rd, alt_o, dir_o}, 9'h104);
    $display("Test reset done");
    print_verdict();
  end
endmodule // tb_dsr_top
